// file: dv/sccmt_asserts.sv
// concurrent checks on the timer's register port, pins and interrupt outputs
`timescale 1ns/1ps
module sccmt_asserts (
	input wire       mclk,
	input wire       rst_n,
	input wire [7:0] bus_addr,
	input wire [7:0] bus_wdata,
	input wire       bus_wr,
	input wire       bus_rd,
	input wire [7:0] bus_rdata,
	input wire       external_timer_clock_pin,
	input wire [5:0] chan_pin_in,
	input wire [5:0] chan_pin_out,
	input wire [5:0] chan_pin_oe_n,
	input wire       irq_overflow,
	input wire [5:0] irq_channel
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire tsc_wr = bus_wr && bus_addr == 8'h20;
	wire c0_wr  = bus_wr && bus_addr == 8'h26;
	a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property ($past(bus_rd) && $past(bus_addr) inside {[8'h00:8'h1F], 8'h21, [8'h38:8'hFF]}
		|-> bus_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_tsc_fixed_bits: assert property ($past(bus_rd) && $past(bus_addr) == 8'h20 |-> bus_rdata[4:3] == 2'h0)
		else $error("timer control bits 4:3 not zero");
	a_odd_link_zero: assert property ($past(bus_rd) && $past(bus_addr) inside {8'h29, 8'h2F, 8'h35}
		|-> !bus_rdata[5])
		else $error("odd channel link bit reads one");
	a_ovf_irq_hold: assert property (irq_overflow && !tsc_wr && !$past(tsc_wr) |=> irq_overflow)
		else $error("overflow request dropped without a control write");
	a_ch_irq_hold: assert property (irq_channel[0] && !c0_wr && !$past(c0_wr) |=> irq_channel[0])
		else $error("channel request dropped without a control write");
	// enables move only as a consequence of a write two edges back
	a_oe_stable: assert property (!$past(bus_wr) && !$past(bus_wr, 2) |-> $stable(chan_pin_oe_n))
		else $error("pin enable changed without a write");
	a_reset_pins: assert property ($rose(rst_n) |-> chan_pin_oe_n == 6'h3F && chan_pin_out == 6'h00
		&& irq_channel == 6'h00 && !irq_overflow)
		else $error("pins or requests active out of reset");
	c_ovf: cover property ($rose(irq_overflow));
	c_capture: cover property ($rose(irq_channel[0]));
	c_drive: cover property ($fell(chan_pin_oe_n[0]));
endmodule // sccmt_asserts

bind sccmt_top sccmt_asserts u_chk (.mclk(mclk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
	.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .external_timer_clock_pin(external_timer_clock_pin),
	.chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out), .chan_pin_oe_n(chan_pin_oe_n),
	.irq_overflow(irq_overflow), .irq_channel(irq_channel));

// file: dv/sccmt_pin_model.sv
// far side of the timer pins: capture inputs and external counter clock
`timescale 1ns/1ps
module sccmt_pin_model (
	input  wire       mclk,
	input  wire [5:0] chan_pin_out,
	input  wire [5:0] chan_pin_oe_n,
	output wire [5:0] chan_pin_in,
	output reg        ext_clk
);
	reg [5:0] drv;
	// a pin the block drives reads back the block's own level
	assign chan_pin_in = (chan_pin_out & ~chan_pin_oe_n) | (drv & chan_pin_oe_n);
	initial begin
		drv = 6'h00;
		ext_clk = 1'b0;
	end
	task set_pin(input integer ch, input reg lvl);
		@(posedge mclk);
		drv[ch] <= lvl;
	endtask
	// each level held gap bus clocks so the sampler sees one edge per pulse
	task ext_pulses(input integer n, input integer gap);
		repeat (n) begin
			repeat (gap) @(posedge mclk);
			ext_clk <= 1'b1;
			repeat (gap) @(posedge mclk);
			ext_clk <= 1'b0;
		end
	endtask
endmodule // sccmt_pin_model

// file: dv/sccmt_top_tb.sv
// self-checking bench for the six channel capture/compare timer
`timescale 1ns/1ps
module sccmt_top_tb;
	reg         mclk;
	reg         rst_n;
	reg  [7:0]  bus_addr;
	reg  [7:0]  bus_wdata;
	reg         bus_wr;
	reg         bus_rd;
	wire [7:0]  bus_rdata;
	wire        ext_clk;
	wire [5:0]  chan_pin_in;
	wire [5:0]  chan_pin_out;
	wire [5:0]  chan_pin_oe_n;
	wire        irq_overflow;
	wire [5:0]  irq_channel;
	integer     n_errors;
	integer     cmp_count;
	integer     i, j, n, h;
	reg  [7:0]  rv, a;
	reg  [1:0]  e;
	reg  [15:0] c, val;
	reg         last;

	sccmt_top DUT (.mclk(mclk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_rdata(bus_rdata), .external_timer_clock_pin(ext_clk), .chan_pin_in(chan_pin_in),
		.chan_pin_out(chan_pin_out), .chan_pin_oe_n(chan_pin_oe_n), .irq_overflow(irq_overflow),
		.irq_channel(irq_channel));
	sccmt_pin_model pm (.mclk(mclk), .chan_pin_out(chan_pin_out), .chan_pin_oe_n(chan_pin_oe_n),
		.chan_pin_in(chan_pin_in), .ext_clk(ext_clk));

	always #4 mclk = ~mclk;

	task chk(input [15:0] seen, input [15:0] exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task stop_test;
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// idle cycle after each strobe keeps one assignment per signal per step
	task wr(input [7:0] ad, input [7:0] d);
		bus_addr <= ad;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge mclk);
		bus_wr <= 1'b0;
		@(posedge mclk);
	endtask
	task rd(input [7:0] ad);
		bus_addr <= ad;
		bus_rd <= 1'b1;
		@(posedge mclk);
		bus_rd <= 1'b0;
		@(posedge mclk);
		rv = bus_rdata;
	endtask
	task wrval(input [7:0] ad, input [15:0] v);
		wr(ad + 8'h01, v[15:8]);
		wr(ad + 8'h02, v[7:0]);
	endtask
	task rdval(input [7:0] ad);
		rd(ad + 8'h01);
		val[15:8] = rv;
		rd(ad + 8'h02);
		val[7:0] = rv;
	endtask
	task measure(input integer ch);
		n = 0;
		h = 0;
		last = chan_pin_out[ch];
		repeat (100) begin
			@(posedge mclk);
			n = n + (chan_pin_out[ch] !== last);
			h = h + chan_pin_out[ch];
			last = chan_pin_out[ch];
		end
	endtask

	task t_reset;
		rd(8'h20);
		chk(rv, 8'h20);
		rdval(8'h21);
		chk(val, 16'h0000);
		rdval(8'h23);
		chk(val, 16'hFFFF);
		for (a = 8'h26; a < 8'h38; a = a + 8'h03) begin
			rd(a);
			chk(rv, 8'h00);
		end
		rd(8'h21);
		chk(rv, 8'h00);
		rd(8'h40);
		chk(rv, 8'h00);
		$display("reset test done");
	endtask
	task t_counter;
		for (i = 0; i < 7; i = i + 1) begin
			wr(8'h20, 8'h30);
			wr(8'h20, {5'h00, i[2:0]});
			repeat (124) @(posedge mclk);
			rdval(8'h21);
			wr(8'h20, {5'h04, i[2:0]});
			rdval(8'h21);
			chk(val + 16'h0002 >= (16'h0082 >> i) && val <= (16'h0082 >> i) + 16'h0001, 1'b1);
		end
		wr(8'h20, 8'h30);
		wr(8'h20, 8'h07);
		pm.ext_pulses(5, 3);
		repeat (4) @(posedge mclk);
		wr(8'h20, 8'h27);
		rdval(8'h21);
		chk(val, 16'h0005);
		wr(8'h20, 8'h30);
		wrval(8'h23, 16'h0009);
		rdval(8'h23);
		chk(val, 16'h0009);
		wr(8'h20, 8'h40);
		repeat (30) @(posedge mclk);
		chk(irq_overflow, 1'b1);
		wr(8'h20, 8'h60);
		rdval(8'h21);
		chk(val <= 16'h0009, 1'b1);
		rd(8'h20);
		chk(rv, 8'hE0);
		wr(8'h20, 8'h20);
		@(posedge mclk);
		chk(irq_overflow, 1'b0);
		wr(8'h20, 8'h30);
		rdval(8'h21);
		chk(val, 16'h0000);
		$display("counter test done");
	endtask
	task t_capture;
		wr(8'h20, 8'h00);
		repeat (6) @(posedge mclk);
		wr(8'h20, 8'h20);
		rdval(8'h21);
		c = val;
		e = 2'h1;
		for (i = 0; i < 6; i = i + 1) begin
			a = 8'h26 + 8'h03 * i[7:0];
			wr(a, {4'h4, e, 2'h0});
			wrval(a, 16'hABCD);
			pm.set_pin(i, 1'b1);
			repeat (2) @(posedge mclk);
			chk(irq_channel[i], 1'b0);
			@(posedge mclk);
			chk(irq_channel[i], e[0]);
			rdval(a);
			chk(val, e[0] ? c : 16'hABCD);
			wrval(a, 16'hABCD);
			pm.set_pin(i, 1'b0);
			repeat (4) @(posedge mclk);
			rdval(a);
			chk(val, e[1] ? c : 16'hABCD);
			e = (e == 2'h3) ? 2'h1 : e + 2'h1;
		end
		$display("capture test done");
	endtask
	task t_compare;
		wrval(8'h26, 16'h0005);
		wr(8'h20, 8'h00);
		rd(8'h26);
		wr(8'h26, 8'h5C);
		measure(0);
		chk(chan_pin_out[0], 1'b1);
		chk(chan_pin_oe_n[0], 1'b0);
		chk(irq_channel[0], 1'b1);
		wr(8'h26, 8'h18);
		measure(0);
		chk(chan_pin_out[0], 1'b0);
		wr(8'h26, 8'h14);
		measure(0);
		chk(n >= 9 && n <= 11, 1'b1);
		wr(8'h26, 8'h1A);
		measure(0);
		chk(n >= 19 && n <= 21, 1'b1);
		wr(8'h26, 8'h10);
		@(posedge mclk);
		chk(chan_pin_oe_n[0], 1'b1);
		$display("compare test done");
	endtask
	// high time per period tells which register pair is active
	task t_link;
		for (j = 0; j < 3; j = j + 1) begin
			a = 8'h26 + 8'h06 * j[7:0];
			wr(a, 8'h2A);
			wrval(a, 16'h0002);
			measure(2 * j);
			chk(h < 40, 1'b1);
			wrval(a + 8'h03, 16'h0007);
			measure(2 * j);
			chk(h > 60, 1'b1);
			wrval(a, 16'h0002);
			measure(2 * j);
			chk(h < 40, 1'b1);
			chk(chan_pin_oe_n[2 * j + 1], 1'b1);
			wr(a + 8'h03, 8'h20);
			rd(a + 8'h03);
			chk(rv[5], 1'b0);
			wr(a, 8'h00);
		end
		$display("link test done");
	endtask
	task t_keep;
		wrval(8'h29, 16'h1234);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		rdval(8'h29);
		chk(val, 16'h1234);
		rd(8'h20);
		chk(rv, 8'h20);
		$display("reset keep test done");
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		n_errors = n_errors + 1;
		stop_test;
	end
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		bus_addr = 8'h00;
		bus_wdata = 8'h00;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		n_errors = 0;
		cmp_count = 0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		t_reset;
		t_counter;
		t_capture;
		t_compare;
		t_link;
		t_keep;
		stop_test;
	end
endmodule // sccmt_top_tb

// file: rtl/sccmt_defs.vh
// register map, field positions, reset values and mode codes of the capture/compare timer
`ifndef SCCMT_DEFS_VH
`define SCCMT_DEFS_VH

// byte addresses on the register port
`define SCCMT_ADDR_TSC     8'h20
`define SCCMT_ADDR_CNT_HI  8'h22
`define SCCMT_ADDR_CNT_LO  8'h23
`define SCCMT_ADDR_MOD_HI  8'h24
`define SCCMT_ADDR_MOD_LO  8'h25
`define SCCMT_ADDR_CH0_SC  8'h26
`define SCCMT_CH_STRIDE    8'h03
`define SCCMT_NUM_CH       6

// timer status and control fields
`define SCCMT_TSC_OVF      7
`define SCCMT_TSC_OVIE     6
`define SCCMT_TSC_HALT     5
`define SCCMT_TSC_CRST     4
`define SCCMT_TSC_PS_HI    2
`define SCCMT_TSC_PS_LO    0

// channel status and control fields
`define SCCMT_CH_FLAG      7
`define SCCMT_CH_IE        6
`define SCCMT_CH_MSB       5
`define SCCMT_CH_MSA       4
`define SCCMT_CH_ELSB      3
`define SCCMT_CH_ELSA      2
`define SCCMT_CH_TOV       1
`define SCCMT_CH_MAX       0

// reset values
`define SCCMT_TSC_RST      8'h20
`define SCCMT_CHSC_RST     8'h00
`define SCCMT_MOD_RST      16'hFFFF
`define SCCMT_CNT_RST      16'h0000

// prescaler select code that picks the external clock pin
`define SCCMT_PS_EXT       3'h7

// edge/level select codes in output compare mode
`define SCCMT_OC_TOGGLE    2'h1
`define SCCMT_OC_CLEAR     2'h2
`define SCCMT_OC_SET       2'h3

`endif

// file: rtl/sccmt_edge_sync.v
// samples the capture pins and the external clock pin and flags their edges
`timescale 1ns/1ps
module sccmt_edge_sync #(
	parameter W = 7
) (
	input  wire         mclk,
	input  wire         rst_n,
	input  wire [W-1:0] pin_in,
	output wire [W-1:0] rise,
	output wire [W-1:0] fall
);

	// pins arrive synchronous to mclk, so one sampling stage suffices
	reg [W-1:0] sampled;
	reg [W-1:0] prev;

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sampled <= {W{1'b0}};
			prev    <= {W{1'b0}};
		end else begin
			sampled <= pin_in;
			prev    <= sampled;
		end
	end

	// one pulse per edge: the pair differs for exactly one cycle
	assign rise = sampled & ~prev;
	assign fall = ~sampled & prev;

endmodule // sccmt_edge_sync

// file: rtl/sccmt_prescaler.v
// divides the bus clock into seven rates or passes external clock edges as counter ticks
`timescale 1ns/1ps
`include "sccmt_defs.vh"
module sccmt_prescaler (
	input  wire       mclk,
	input  wire       rst_n,
	input  wire       clr,
	input  wire       run,
	input  wire [2:0] ps,
	input  wire       ext_rise,
	output reg        tick
);

	reg  [5:0] div;
	reg  [5:0] mask;

	// ps = n divides by 2**n; the tick comes when the low n bits are all ones
	always @* begin
		case (ps)
			3'h0:    mask = 6'h00;
			3'h1:    mask = 6'h01;
			3'h2:    mask = 6'h03;
			3'h3:    mask = 6'h07;
			3'h4:    mask = 6'h0F;
			3'h5:    mask = 6'h1F;
			3'h6:    mask = 6'h3F;
			default: mask = 6'h00;
		endcase
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div  <= 6'h00;
			tick <= 1'b0;
		end else if (clr) begin
			div  <= 6'h00;
			tick <= 1'b0;
		end else if (!run) begin
			tick <= 1'b0;
		end else begin
			div <= div + 6'h01;
			if (ps == `SCCMT_PS_EXT) begin
				tick <= ext_rise;
			end else begin
				tick <= ((div & mask) == mask);
			end
		end
	end

endmodule // sccmt_prescaler

// file: rtl/sccmt_top.v
// six channel capture/compare timer: counter, prescaler, channels and register port
//
// Functional notes
// - one 16-bit counter times all channels, free running or modulo up-count
// - the modulo limit comes from the high and low modulo registers
// - software may read the counter any time without disturbing the count
// - six channels, each set by software as capture or compare
// - prescaler select picks one of seven bus clock rates or the external clock
// - two edge select bits choose the capture edge polarity
// - an active capture edge copies the counter into the channel value registers
// - capture happens on every qualifying edge whatever the event flag holds
// - the captured count is stored two bus cycles after the pin event
// - a set channel flag requests an interrupt when its enable is set
// - reset leaves channel value registers untouched
// - compare match sets, clears or toggles the channel pin as configured
// - a compare match can request an interrupt like a capture
// - unbuffered compare uses the freshly written value at once
// - link bit on channel 0, 2 or 4 pairs it with the next odd channel
// - even registers rule first; an odd write takes over after next overflow
// - at each later overflow the most recently written pair becomes active
// - linked: even control rules the pair, odd control unused, odd pin freed
// - capture on rising, falling or any edge, chosen per channel
// - toggle-on-overflow bit toggles the channel pin at counter overflow in compare mode
// - halt bit stops counting, counter reset bit clears counter and prescaler
`timescale 1ns/1ps
`include "sccmt_defs.vh"
module sccmt_top (
	input  wire       mclk,
	input  wire       rst_n,
	input  wire [7:0] bus_addr,
	input  wire [7:0] bus_wdata,
	input  wire       bus_wr,
	input  wire       bus_rd,
	output reg  [7:0] bus_rdata,
	input  wire       external_timer_clock_pin,
	input  wire [5:0] chan_pin_in,
	output wire [5:0] chan_pin_out,
	output wire [5:0] chan_pin_oe_n,
	output reg        irq_overflow,
	output wire [5:0] irq_channel
);

	localparam NCH = `SCCMT_NUM_CH;
	localparam EXT_BIT = 6;

	reg  [7:0]       tsc;
	reg  [15:0]      cnt;
	reg  [15:0]      modulo_limit;
	reg  [7:0]       cnt_lo_latch;
	reg              lo_latched;
	reg              ovf_arm;
	reg              cnt_new;
	reg              ovf_ev;
	reg  [7:0]       ch_rd_or;
	integer          k;

	wire             tick;
	wire [6:0]       pin_rise;
	wire [6:0]       pin_fall;
	wire [8*NCH-1:0] ch_rd;
	wire [16*NCH-1:0] ch_val_w;
	wire [NCH-1:0]   ch_wr_w;
	wire [NCH-1:0]   link_w;

	wire             halt      = tsc[`SCCMT_TSC_HALT];
	wire [2:0]       prescaler_select = tsc[`SCCMT_TSC_PS_HI:`SCCMT_TSC_PS_LO];
	wire             w_tsc     = bus_wr && (bus_addr == `SCCMT_ADDR_TSC);
	wire             r_tsc     = bus_rd && (bus_addr == `SCCMT_ADDR_TSC);
	wire             crst_wr   = w_tsc && bus_wdata[`SCCMT_TSC_CRST];
	wire             next_ovf_flag;
	wire             overflow_flag       = tsc[`SCCMT_TSC_OVF];
	wire             overflow_irq_enable = tsc[`SCCMT_TSC_OVIE];
	// byte strobes of the counter and modulo pairs
	wire             w_mod_hi  = bus_wr && (bus_addr == `SCCMT_ADDR_MOD_HI);
	wire             w_mod_lo  = bus_wr && (bus_addr == `SCCMT_ADDR_MOD_LO);
	wire             r_cnt_hi  = bus_rd && (bus_addr == `SCCMT_ADDR_CNT_HI);
	wire             r_cnt_lo  = bus_rd && (bus_addr == `SCCMT_ADDR_CNT_LO);


	// bit 6 carries the external clock pin, bits 5:0 the channel pins
	sccmt_edge_sync #(
		.W (7)
	) u_sync (
		.mclk   (mclk),
		.rst_n  (rst_n),
		.pin_in ({external_timer_clock_pin, chan_pin_in}),
		.rise   (pin_rise),
		.fall   (pin_fall)
	);

	// counter reset clears the divider too, so the first tick after it is a full period
	sccmt_prescaler u_presc (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.clr      (crst_wr),
		.run      (~halt),
		.ps       (prescaler_select),
		.ext_rise (pin_rise[EXT_BIT]),
		.tick     (tick)
	);

	// counter; a modulo limit of all ones gives free-running behaviour
	// limitation: there is no separate free-run mode, software leaves the limit at all ones
	// cnt_new marks the one cycle in which the channels may look for a match
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt     <= `SCCMT_CNT_RST;
			cnt_new <= 1'b0;
			ovf_ev  <= 1'b0;
		end else begin
			cnt_new <= 1'b0;
			ovf_ev  <= 1'b0;
			if (crst_wr) begin
				cnt <= `SCCMT_CNT_RST;
			// halt is tested here as well, so a tick already in flight is dropped
			end else if (tick && !halt) begin
				cnt_new <= 1'b1;
				if (cnt == modulo_limit) begin
					cnt    <= `SCCMT_CNT_RST;
					ovf_ev <= 1'b1;
				end else begin
					cnt <= cnt + 16'h0001;
				end
			end
		end
	end

	// flag clears by reading it set then writing zero; a same-cycle overflow wins
	assign next_ovf_flag = ovf_ev |
		(overflow_flag & ~(w_tsc & ovf_arm & ~bus_wdata[`SCCMT_TSC_OVF]));

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tsc          <= `SCCMT_TSC_RST;
			ovf_arm      <= 1'b0;
			irq_overflow <= 1'b0;
			modulo_limit <= `SCCMT_MOD_RST;
		end else begin
			tsc[`SCCMT_TSC_OVF] <= next_ovf_flag;
			// the request follows the flag with no extra delay
			irq_overflow        <= next_ovf_flag & overflow_irq_enable;
			// any write drops the arm, so a clear needs a fresh read of the set flag
			if (w_tsc) begin
				tsc[6:5] <= bus_wdata[6:5];
				tsc[2:0] <= bus_wdata[2:0];
				ovf_arm  <= 1'b0;
			end else if (r_tsc && overflow_flag) begin
				ovf_arm <= 1'b1;
			end
			// the reset bit is a strobe and bit 3 is unused: both stay zero
			tsc[4:3] <= 2'h0;
			// each modulo byte takes effect on its own write
			if (w_mod_hi) begin
				modulo_limit[15:8] <= bus_wdata;
			end
			if (w_mod_lo) begin
				modulo_limit[7:0] <= bus_wdata;
			end
		end
	end

	// reading the high byte freezes the low byte, so a two-byte read is coherent
	// a low read with no high read before it shows the live low byte
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_lo_latch <= 8'h00;
			lo_latched   <= 1'b0;
		end else if (r_cnt_hi) begin
			cnt_lo_latch <= cnt[7:0];
			lo_latched   <= 1'b1;
		end else if (r_cnt_lo) begin
			lo_latched <= 1'b0;
		end
	end

	genvar i;
	generate
		for (i = 0; i < NCH; i = i + 1) begin : g_ch
			// address arithmetic in integer, cut to the byte address on purpose
			localparam integer A_SC_I = `SCCMT_ADDR_CH0_SC + i * `SCCMT_CH_STRIDE;
			localparam [7:0] A_SC = A_SC_I[7:0];
			localparam [7:0] A_HI = A_SC + 8'h01;
			localparam [7:0] A_LO = A_SC + 8'h02;

			reg  [7:0]  sc;
			reg  [15:0] val;
			reg         arm;
			reg         pin;
			reg         oe_n;
			reg         irq;
			wire [15:0] cmp_val;
			wire        freed;
			wire        buffered;

			wire w_sc = bus_wr && (bus_addr == A_SC);
			wire w_hi = bus_wr && (bus_addr == A_HI);
			wire w_lo = bus_wr && (bus_addr == A_LO);
			wire r_sc = bus_rd && (bus_addr == A_SC);
			wire r_hi = bus_rd && (bus_addr == A_HI);
			wire r_lo = bus_rd && (bus_addr == A_LO);

			wire [1:0] els      = sc[`SCCMT_CH_ELSB:`SCCMT_CH_ELSA];
			wire       channel_event_flag = sc[`SCCMT_CH_FLAG];
			wire       ch_irq_en          = sc[`SCCMT_CH_IE];
			wire       toggle_on_overflow = sc[`SCCMT_CH_TOV];

			wire       mode_in  = !freed && (sc[`SCCMT_CH_MSB:`SCCMT_CH_MSA] == 2'h0);
			wire       mode_out = !freed && (buffered || sc[`SCCMT_CH_MSB:`SCCMT_CH_MSA] == 2'h1);
			// an edge counts only in capture mode; both select bits give any edge
			wire       cap_rise = els[0] && pin_rise[i];
			wire       cap_fall = els[1] && pin_fall[i];
			wire       cap_ev   = mode_in && (cap_rise || cap_fall);
			// match only after a count step, so a halted counter on the value matches once
			wire       match    = mode_out && cnt_new && (cnt == cmp_val);
			wire       next_flag = cap_ev | match |
				(channel_event_flag & ~(w_sc & arm & ~bus_wdata[`SCCMT_CH_FLAG]));

			if (i % 2 == 0) begin : g_even
				// active_odd: which register pair drives the compare
				reg active_odd;
				// pending_odd: which register pair was written last
				reg pending_odd;

				assign buffered = sc[`SCCMT_CH_MSB];
				assign freed    = 1'b0;
				assign cmp_val  = (buffered && active_odd) ? ch_val_w[16*(i+1) +: 16] : val;

				always @(posedge mclk or negedge rst_n) begin
					if (!rst_n) begin
						active_odd  <= 1'b0;
						pending_odd <= 1'b0;
					end else if (!buffered) begin
						active_odd  <= 1'b0;
						pending_odd <= 1'b0;
					end else begin
						// a write is remembered at once, but the source swaps only at overflow,
						// so one compare period never switches between the two register pairs
						if (ch_wr_w[i+1]) begin
							pending_odd <= 1'b1;
						end else if (ch_wr_w[i]) begin
							pending_odd <= 1'b0;
						end
						if (ovf_ev) begin
							active_odd <= pending_odd;
						end
					end
				end
			end else begin : g_odd
				// a freed odd channel neither captures nor compares, and releases its pin
				assign buffered = 1'b0;
				assign freed    = link_w[i-1];
				assign cmp_val  = val;
			end

			// the value registers carry no reset so captured data survives it
			// capture wins over a software write landing in the same cycle
			always @(posedge mclk) begin
				if (cap_ev) begin
					val <= cnt;
				end else if (w_hi) begin
					val[15:8] <= bus_wdata;
				end else if (w_lo) begin
					val[7:0] <= bus_wdata;
				end
			end

			always @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					sc   <= `SCCMT_CHSC_RST;
					arm  <= 1'b0;
					irq  <= 1'b0;
					pin  <= 1'b0;
					// pins start released so nothing is driven before software picks a mode
					oe_n <= 1'b1;
				end else begin
					sc[`SCCMT_CH_FLAG] <= next_flag;
					irq <= next_flag & ch_irq_en;
					if (w_sc) begin
						sc[6:0] <= bus_wdata[6:0];
						// only even channels own a link bit
						if (i % 2 == 1) begin
							sc[`SCCMT_CH_MSB] <= 1'b0;
						end
						arm <= 1'b0;
					end else if (r_sc && channel_event_flag) begin
						arm <= 1'b1;
					end
					oe_n <= !(mode_out && els != 2'h0);
					// a match outranks toggle-on-overflow when both fall in one cycle
					if (mode_out && match) begin
						case (els)
							`SCCMT_OC_TOGGLE: pin <= ~pin;
							`SCCMT_OC_CLEAR:  pin <= 1'b0;
							`SCCMT_OC_SET:    pin <= 1'b1;
							default:          pin <= pin;
						endcase
					end else if (mode_out && ovf_ev && toggle_on_overflow) begin
						pin <= ~pin;
					end
				end
			end

			assign ch_val_w[16*i +: 16] = val;
			assign ch_wr_w[i]           = w_hi | w_lo;
			assign link_w[i]            = buffered;
			assign chan_pin_out[i]      = pin;
			assign chan_pin_oe_n[i]     = oe_n;
			assign irq_channel[i]       = irq;
			// an unselected channel reads zero so the read mux can simply or them
			assign ch_rd[8*i +: 8]      = r_sc ? sc :
				(r_hi ? val[15:8] :
				(r_lo ? val[7:0] : 8'h00));
		end
	endgenerate

	// channel read data: at most one channel decodes, the rest contribute zero
	always @* begin
		ch_rd_or = 8'h00;
		for (k = 0; k < NCH; k = k + 1) begin
			ch_rd_or = ch_rd_or | ch_rd[8*k +: 8];
		end
	end

	// read data stands in the cycle after the strobe only; unmapped reads give zero
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata <= 8'h00;
		end else if (!bus_rd) begin
			bus_rdata <= 8'h00;
		end else begin
			case (bus_addr)
				`SCCMT_ADDR_TSC:    bus_rdata <= tsc;
				`SCCMT_ADDR_CNT_HI: bus_rdata <= cnt[15:8];
				// the low byte comes from the latch while a high read holds it
				`SCCMT_ADDR_CNT_LO: bus_rdata <= lo_latched ? cnt_lo_latch : cnt[7:0];
				`SCCMT_ADDR_MOD_HI: bus_rdata <= modulo_limit[15:8];
				`SCCMT_ADDR_MOD_LO: bus_rdata <= modulo_limit[7:0];
				default:            bus_rdata <= ch_rd_or;
			endcase
		end
	end

endmodule // sccmt_top
